// [tb_twi_host.sv]
// self-checking bench for the two-wire host with a target device model
`timescale 1ns/100ps
`default_nettype none
module tb_twi_host;
  import twi_host_pkg::*;
  localparam logic [6:0] TADDR = 7'h2a;
  localparam logic [7:0] TVAL = 8'h3c;
  localparam logic [31:0] C_S = 32'h1 << CMD_START;
  localparam logic [31:0] C_W = 32'h1 << CMD_WRITE;
  localparam logic [31:0] C_R = 32'h1 << CMD_READ;
  localparam logic [31:0] C_P = 32'h1 << CMD_STOP;
  localparam logic [31:0] C_N = 32'h1 << CMD_NACK;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, stretch = 1'b0, rogue = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic ack, scl_o, scl_oe, sda_o, sda_oe, t_scl, t_sda, scl_w, sda_w;
  logic [7:0] rx_byte;
  logic overrun;
  logic rx_take = 1'b0;
  int miscompares = 0;
  int samples_checked = 0;
  always #20 mclk = ~mclk;
  // open-drain lines with pull-ups: low while anyone pulls
  assign scl_w = !(scl_oe | t_scl);
  assign sda_w = !(sda_oe | t_sda | rogue);
  twi_host u_twi_host (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
  twi_target_model #(.ADDR(TADDR)) u_twi_target_model (.scl(scl_w), .sda(sda_w), .stretch(stretch),
    .tx_val(TVAL), .rx_take(rx_take), .scl_pull(t_scl), .sda_pull(t_sda), .rx_byte(rx_byte), .overrun(overrun));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_up(input string name);
    miscompares++;
    $display("MISMATCH %s expected %h seen %h", name, 1, 0);
    end_of_test();
  endtask
  // one classic cycle: hold the request until ack is sampled, then idle a cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) give_up("ack");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, REG_STAT, 32'h0);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) give_up("busy");
  endtask
  task automatic run(input logic [7:0] txd, input logic [31:0] cmd);
    bus(1'b1, REG_TXD, {24'h0, txd});
    bus(1'b1, REG_CMD, cmd);
    idle();
  endtask
  task automatic t_reset();
    chk("pins", {28'h0, scl_oe, sda_oe, scl_o, sda_o}, 32'h0);
    bus(1'b0, REG_STAT, 32'h0);
    chk("stat", q, 32'h0);
    bus(1'b0, REG_DIV, 32'h0);
    chk("div", q, {16'h0, DIV_RESET});
    bus(1'b0, 8'h18, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask
  // address write then a data byte with stop; the bit period is measured on the wire
  task automatic t_write();
    int n;
    int m;
    n = 0;
    m = 0;
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b1, REG_DIV, 32'h2);
    run({TADDR, 1'b0}, C_S | C_W);
    chk("addr_nack", q[ST_NACK], 1'b0);
    chk("bus_taken", q[ST_BUS], 1'b1);
    bus(1'b1, REG_TXD, 32'h0000_00a5);
    bus(1'b1, REG_CMD, C_W | C_P);
    while (scl_w !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 200) give_up("scl_rise");
    while (scl_w !== 1'b0 && m < 200) begin
      @(posedge mclk);
      m++;
    end
    while (scl_w !== 1'b1 && m < 200) begin
      @(posedge mclk);
      m++;
    end
    chk("bit_cycles", m, 4 * (2 + 1));
    idle();
    chk("rx_byte", rx_byte, 8'ha5);
    chk("no_overrun", overrun, 1'b0);
    chk("bus_busy", q[ST_BUS], 1'b0);
    // software takes the byte so the target buffer is free again
    rx_take <= 1'b1;
    @(posedge mclk);
    rx_take <= 1'b0;
  endtask
  // read with the target stretching the clock after the address acknowledge; the final master nack clears addressed, so no stretch follows it
  task automatic t_read();
    stretch <= 1'b1;
    run({TADDR, 1'b1}, C_S | C_W);
    chk("rd_addr_nack", q[ST_NACK], 1'b0);
    run(8'h00, C_R | C_N | C_P);
    chk("rxf", q[ST_RXF], 1'b1);
    bus(1'b0, REG_RXD, 32'h0);
    chk("rxd", q, {24'h0, TVAL});
    bus(1'b0, REG_STAT, 32'h0);
    chk("rxf_clr", q[ST_RXF], 1'b0);
    stretch <= 1'b0;
  endtask
  task automatic t_restart();
    run({TADDR, 1'b0}, C_S | C_W);
    run(8'h11, C_W);
    run(8'h22, C_W); // lands on the unread target buffer, so it is dropped
    run({TADDR, 1'b1}, C_S | C_W);
    chk("rs_nack", q[ST_NACK], 1'b0);
    run(8'h00, C_R | C_N | C_P);
    chk("rs_rx", rx_byte, 8'h11);
    chk("overrun", overrun, 1'b1);
    bus(1'b0, REG_RXD, 32'h0);
    chk("rs_rxd", q, {24'h0, TVAL});
  endtask
  task automatic t_nack();
    run({TADDR ^ 7'h01, 1'b0}, C_S | C_W | C_P);
    chk("wrong_addr", q[ST_NACK], 1'b1);
  endtask
  // another driver pulls sda low during scl low while the host sends a one
  task automatic t_arb();
    int n;
    n = 0;
    bus(1'b1, REG_TXD, 32'h0000_00ff);
    bus(1'b1, REG_CMD, C_S | C_W);
    while (!(scl_oe === 1'b1) && n < 300) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 300) give_up("start_hold");
    // scl is low now, so the other driver moves sda only where data may change
    rogue <= 1'b1;
    idle();
    chk("arb", q[ST_ARB], 1'b1);
    chk("arb_release", {30'h0, scl_oe, sda_oe}, 32'h0);
    rogue <= 1'b0;
    bus(1'b1, REG_STAT, 32'h1 << ST_ARB);
    bus(1'b0, REG_STAT, 32'h0);
    chk("arb_clr", q[ST_ARB], 1'b0);
  endtask
  // disabled port ignores commands and leaves both lines released
  task automatic t_off();
    // start with stop and no byte must still show a real stop edge
    run(8'h80, C_S | C_P);
    chk("stop_only_bus", q[ST_BUS], 1'b0);
    chk("stop_only_pins", {30'h0, scl_oe, sda_oe}, 32'h0);
    bus(1'b1, REG_CTRL, 32'h0);
    bus(1'b1, REG_CMD, C_S);
    bus(1'b0, REG_STAT, 32'h0);
    chk("off_busy", q[ST_BUSY], 1'b0);
    chk("off_pins", {30'h0, scl_oe, sda_oe}, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_write();
    t_read();
    t_restart();
    t_nack();
    t_arb();
    t_off();
    end_of_test();
  end
endmodule
`default_nettype wire

// [twi_host.sv]
// two-wire bus master with a classic wishbone register slave
//
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/100ps
`default_nettype none
module twi_host
  import twi_host_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  // level for the current bit: pull low for a zero, release for a one
  function automatic logic sda_pull(input logic rd, input logic [3:0] bitn, input logic msb, input logic nack);
    if (bitn == ACK_SLOT) begin
      sda_pull = rd ? !nack : 1'b0;
    end else begin
      sda_pull = rd ? 1'b0 : !msb;
    end
  endfunction

  logic scl_m_ff, scl_s_ff, sda_m_ff, sda_s_ff, sda_p_ff, bus_ff, nxt_bus;
  logic ack_ff, nxt_ack, en_ff, nxt_en;
  logic [31:0] dat_ff, nxt_dat;
  logic [15:0] div_ff, nxt_div, cnt_ff, nxt_cnt;
  logic [7:0] txd_ff, nxt_txd, rxd_ff, nxt_rxd, sh_ff, nxt_sh;
  eng_state_t state_ff, nxt_state;
  logic [1:0] phase_ff, nxt_phase;
  logic [3:0] bit_ff, nxt_bit;
  logic scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
  logic rd_ff, nxt_rd, stop_ff, nxt_stop, nack_ff, nxt_nack, wr_ff, nxt_wr;
  logic rxf_ff, nxt_rxf, got_nack_ff, nxt_got_nack, arb_ff, nxt_arb;
  logic wr_en, rd_en, cmd_go, advance;

  // pins are open drain: the only level ever driven is low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_ff;
  assign sda_oe = sda_oe_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // bus lines cross in through two flops; the second is used, and sda gets a third flop for start and stop detection
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_p_ff <= 1'b1;
    end else begin
      scl_m_ff <= scl_i;
      scl_s_ff <= scl_m_ff;
      sda_m_ff <= sda_i;
      sda_s_ff <= sda_m_ff;
      sda_p_ff <= sda_s_ff;
    end
  end

  // wishbone: ack one cycle after the request, writes land on the ack edge
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
  assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && ack_ff;
  always_comb begin
    nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
    nxt_dat = dat_ff;
    nxt_en = en_ff;
    nxt_div = div_ff;
    nxt_txd = txd_ff;
    nxt_bus = bus_ff;
    if (nxt_ack) begin
      unique case (wb_adr_i)
        REG_CTRL: nxt_dat = {31'h0, en_ff};
        REG_DIV: nxt_dat = {16'h0, div_ff};
        REG_TXD: nxt_dat = {24'h0, txd_ff};
        REG_RXD: nxt_dat = {24'h0, rxd_ff};
        REG_STAT: nxt_dat = {27'h0, bus_ff, rxf_ff, arb_ff, got_nack_ff, state_ff != S_IDLE};
        default: nxt_dat = 32'h0;
      endcase
    end
    if (wr_en && wb_sel_i[0]) begin
      if (wb_adr_i == REG_CTRL) nxt_en = wb_dat_i[CTRL_EN];
      if (wb_adr_i == REG_DIV) nxt_div[7:0] = wb_dat_i[7:0];
      if (wb_adr_i == REG_TXD) nxt_txd = wb_dat_i[7:0];
    end
    if (wr_en && wb_sel_i[1] && wb_adr_i == REG_DIV) nxt_div[15:8] = wb_dat_i[15:8];
    // track other masters: start marks the bus taken, stop frees it
    if (scl_s_ff && sda_p_ff && !sda_s_ff) nxt_bus = 1'b1;
    if (scl_s_ff && !sda_p_ff && sda_s_ff) nxt_bus = 1'b0;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
      en_ff <= 1'b0;
      div_ff <= DIV_RESET;
      txd_ff <= 8'h0;
      bus_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      en_ff <= nxt_en;
      div_ff <= nxt_div;
      txd_ff <= nxt_txd;
      bus_ff <= nxt_bus;
    end
  end

  // a command is taken only when idle; data or stop alone need scl already held low
  assign cmd_go = wr_en && wb_sel_i[0] && wb_adr_i == REG_CMD && state_ff == S_IDLE && en_ff &&
                  (wb_dat_i[CMD_START] || scl_oe_ff);
  // phase 1 waits for scl to be seen high, so a stretching slave stalls us
  assign advance = (cnt_ff == 16'h0) && (phase_ff != 2'd1 || scl_s_ff);

  // bit engine: four quarter phases per bit, actions happen when a phase ends
  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_rd = rd_ff;
    nxt_stop = stop_ff;
    nxt_nack = nack_ff;
    nxt_rxd = rxd_ff;
    nxt_rxf = rxf_ff;
    nxt_got_nack = got_nack_ff;
    nxt_arb = arb_ff;
    if (rd_en && wb_adr_i == REG_RXD) nxt_rxf = 1'b0;
    if (wr_en && wb_sel_i[0] && wb_adr_i == REG_STAT && wb_dat_i[ST_ARB]) nxt_arb = 1'b0;
    if (state_ff != S_IDLE) begin
      if (cnt_ff != 16'h0) nxt_cnt = cnt_ff - 16'h1;
      else if (advance) nxt_cnt = div_ff;
      if (advance) nxt_phase = phase_ff + 2'd1;
    end
    if (!en_ff) begin
      nxt_state = S_IDLE;
      nxt_scl_oe = 1'b0;
      nxt_sda_oe = 1'b0;
    end else begin
      unique case (state_ff)
        S_IDLE: begin
          if (cmd_go) begin
            nxt_rd = wb_dat_i[CMD_READ];
            nxt_stop = wb_dat_i[CMD_STOP];
            nxt_nack = wb_dat_i[CMD_NACK];
            nxt_sh = txd_ff; // shifter loads only between bytes
            nxt_bit = 4'h0;
            nxt_phase = 2'd0;
            nxt_cnt = div_ff;
            if (wb_dat_i[CMD_START]) begin
              nxt_state = S_START;
              nxt_sda_oe = 1'b0; // scl is low or the bus idles here
            end else if (wb_dat_i[CMD_READ] || wb_dat_i[CMD_WRITE]) begin
              nxt_state = S_DATA;
              nxt_sda_oe = sda_pull(wb_dat_i[CMD_READ], 4'h0, txd_ff[7], wb_dat_i[CMD_NACK]);
            end else begin
              nxt_state = S_STOP;
              nxt_sda_oe = 1'b1;
            end
          end
        end
        S_START: begin
          if (advance) begin
            unique case (phase_ff)
              2'd0: nxt_scl_oe = 1'b0;
              2'd1: nxt_sda_oe = 1'b1; // sda falls while scl high: start or repeated start
              2'd2: nxt_scl_oe = 1'b1;
              2'd3: begin
                if (rd_ff || wr_ff) begin
                  // address byte with direction bit comes next from the shifter
                  nxt_state = S_DATA;
                  nxt_sda_oe = sda_pull(rd_ff, 4'h0, sh_ff[7], nack_ff);
                end else begin
                  // no byte: keep sda low so a following stop shows a real rising edge
                  nxt_state = stop_ff ? S_STOP : S_IDLE;
                  nxt_sda_oe = 1'b1;
                end
              end
            endcase
          end
        end
        S_DATA: begin
          if (advance) begin
            unique case (phase_ff)
              2'd0: nxt_scl_oe = 1'b0;
              2'd1: begin
                // sample after scl is seen high
                if (bit_ff == ACK_SLOT) begin
                  if (!rd_ff) nxt_got_nack = sda_s_ff; // slave answer to our byte
                  else begin
                    nxt_rxd = sh_ff;
                    nxt_rxf = 1'b1;
                  end
                end else if (!rd_ff && !sda_oe_ff && !sda_s_ff) begin
                  // released for a one but line is low: another master won
                  nxt_state = S_IDLE;
                  nxt_scl_oe = 1'b0;
                  nxt_sda_oe = 1'b0;
                  nxt_arb = 1'b1;
                end else begin
                  nxt_sh = {sh_ff[6:0], sda_s_ff};
                end
              end
              2'd2: nxt_scl_oe = 1'b1;
              2'd3: begin
                nxt_bit = bit_ff + 4'h1;
                if (bit_ff == ACK_SLOT) begin
                  nxt_state = stop_ff ? S_STOP : S_IDLE;
                  nxt_sda_oe = stop_ff; // scl is low, so sda may move
                end else begin
                  // next bit, msb first; ack slot releases or acks
                  nxt_sda_oe = sda_pull(rd_ff, bit_ff + 4'h1, sh_ff[7], nack_ff);
                end
              end
            endcase
          end
        end
        S_STOP: begin
          if (advance) begin
            unique case (phase_ff)
              2'd0: nxt_scl_oe = 1'b0;
              2'd1: nxt_sda_oe = 1'b0; // sda rises while scl high
              2'd2: nxt_sda_oe = 1'b0;
              2'd3: nxt_state = S_IDLE;
            endcase
          end
        end
        default: begin
          nxt_state = S_IDLE;
          nxt_scl_oe = 1'b0;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // remember whether the accepted command carries a byte to write
  always_comb begin
    nxt_wr = wr_ff;
    if (cmd_go) nxt_wr = wb_dat_i[CMD_WRITE];
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= S_IDLE;
      phase_ff <= 2'd0;
      cnt_ff <= 16'h0;
      bit_ff <= 4'h0;
      sh_ff <= 8'h0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      stop_ff <= 1'b0;
      nack_ff <= 1'b0;
      rxd_ff <= 8'h0;
      rxf_ff <= 1'b0;
      got_nack_ff <= 1'b0;
      arb_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      stop_ff <= nxt_stop;
      nack_ff <= nxt_nack;
      rxd_ff <= nxt_rxd;
      rxf_ff <= nxt_rxf;
      got_nack_ff <= nxt_got_nack;
      arb_ff <= nxt_arb;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !ack_ff |=> ack_ff) else $error("no wishbone ack");
  AST_SDA_STILL: assert property (state_ff == S_DATA && phase_ff == 2'd2 |=> $stable(sda_oe_ff))
    else $error("sda moved while scl high");
  AST_START: assert property (state_ff == S_START && phase_ff == 2'd1 && advance |=> sda_oe_ff && !scl_oe_ff)
    else $error("bad start");
  AST_STOP: assert property (state_ff == S_STOP && phase_ff == 2'd1 && advance |=> !sda_oe_ff && !scl_oe_ff)
    else $error("bad stop");
  AST_MSB: assert property (state_ff == S_DATA && !rd_ff && bit_ff < ACK_SLOT && phase_ff == 2'd1
    |-> sda_oe_ff == !sh_ff[7])
    else $error("wrong data bit");
  AST_ACK_FREE: assert property (state_ff == S_DATA && !rd_ff && bit_ff == ACK_SLOT && phase_ff == 2'd1
    |-> !sda_oe_ff)
    else $error("sda held in ack slot");
  AST_MASTER_ACK: assert property (state_ff == S_DATA && rd_ff && bit_ff == ACK_SLOT && phase_ff == 2'd1
    |-> sda_oe_ff == !nack_ff)
    else $error("wrong master ack");
  AST_STRETCH: assert property (state_ff != S_IDLE && phase_ff == 2'd1 && !scl_s_ff |=> phase_ff == 2'd1)
    else $error("ran past stretched scl");
  AST_ARB: assert property (state_ff == S_DATA && !rd_ff && bit_ff < ACK_SLOT && phase_ff == 2'd1 && advance
    && !sda_oe_ff && !sda_s_ff |=> arb_ff && state_ff == S_IDLE && !sda_oe_ff ##1 !scl_oe_ff)
    else $error("arbitration loss missed");
  COV_START: cover property (state_ff == S_START ##1 state_ff == S_DATA);
  COV_STOP: cover property (state_ff == S_STOP ##1 state_ff == S_IDLE);
  COV_READ: cover property (state_ff == S_DATA && rd_ff ##1 rxf_ff);
  COV_ARB: cover property ($rose(arb_ff));
endmodule
`default_nettype wire

// [twi_host_pkg.sv]
// constants, register map and state codes of the two-wire bus controller
package twi_host_pkg;
  localparam int MCLK_HZ = 25000000;
  localparam int BIT_RATE_HZ = 100000;
  // cycles per quarter bit, minus one; keep it at two or more
  localparam logic [15:0] DIV_RESET = 16'(MCLK_HZ / (4 * BIT_RATE_HZ) - 1);
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_DIV = 8'h08;
  localparam logic [7:0] REG_TXD = 8'h0c;
  localparam logic [7:0] REG_RXD = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam int CTRL_EN = 0;
  localparam int CMD_START = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_READ = 2;
  localparam int CMD_STOP = 3;
  localparam int CMD_NACK = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int ST_ARB = 2;
  localparam int ST_RXF = 3;
  localparam int ST_BUS = 4;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_START = 4'b0010,
    S_DATA = 4'b0100,
    S_STOP = 4'b1000
  } eng_state_t;
endpackage

// [twi_target_model.sv]
// behavioural two-wire target device answering the host on the resolved lines
`timescale 1ns/100ps
`default_nettype none
module twi_target_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic stretch,
  input wire logic [7:0] tx_val,
  input wire logic rx_take,
  output logic scl_pull,
  output logic sda_pull,
  output logic [7:0] rx_byte,
  output logic overrun
);
  logic [7:0] sh = 8'h00;
  int bitn = 0;
  logic active = 1'b0, first = 1'b0, addressed = 1'b0, reading = 1'b0;
  logic rx_full = 1'b0;
  // outputs only ever pull low; the bench pull-up makes the ones
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    rx_byte = 8'h00;
    overrun = 1'b0;
  end
  // software reading the buffer frees it for the next byte
  always @(posedge rx_take) rx_full = 1'b0;
  // sda edges while scl is high frame the message; start, address phase and direction are tracked
  always @(negedge sda) if (scl) begin
    active = 1'b1;
    bitn = 0;
    first = 1'b1;
    addressed = 1'b0;
    reading = 1'b0;
  end
  always @(posedge sda) if (scl) begin
    active = 1'b0;
    addressed = 1'b0;
  end
  // sample on the rising edge, msb first; a master nack ends our sending
  always @(posedge scl) if (active) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    bitn++;
    if (bitn == 9 && reading && sda) begin
      reading = 1'b0;
      addressed = 1'b0;
    end
  end
  // data only moves while scl is low
  always @(negedge scl) if (active) begin
    if (bitn == 8) begin
      if (first) begin
        first = 1'b0;
        if (sh[7:1] == ADDR) begin // 7-bit target address match
          addressed = 1'b1;
          reading = sh[0];
          sda_pull = 1'b1;
        end
      end else if (addressed && !reading) begin
        // a byte landing on an unread buffer is lost and flagged
        if (rx_full) overrun = 1'b1;
        else rx_byte = sh;
        rx_full = 1'b1;
        sda_pull = 1'b1;
      end else sda_pull = 1'b0;
    end else if (bitn == 9) begin
      bitn = 0;
      sda_pull = addressed && reading && !tx_val[7];
      // hold the clock low for a while to model a slow target
      if (stretch && addressed) begin
        scl_pull = 1'b1;
        #3000;
        scl_pull = 1'b0;
      end
    end else if (addressed && reading && bitn > 0) sda_pull = !tx_val[7 - bitn];
  end
endmodule
`default_nettype wire
